// file: design/sdfc_top.sv
/*
 * dual fifo control for one serial channel: two 16-entry byte fifos,
 * role select, save/reload of the transmit read pointer, counts,
 * receive threshold and idle detection, axi4-lite registers.
 * assumes one clock; shift logic sits on the same clock and owns
 * tx/rx enables, the transmit data register and the receive errors.
 */
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sdfc_params.svh"
`default_nettype none
// Operation
// - role bit 0: fifo1 transmits, fifo2 receives; 1 reverses them
// - clearing fifos keeps role bit; role changes only with both enables off
// - lost flag sets on transmit write at saved pointer when enabled
// - lost flag clears on fifo clear or save write
// - reload copies saved pointer, self-clears, blocks non-clear control writes meanwhile
// - reload request ignored while fifo enabled or transmitting
// - save stores transmit read pointer only when transmit count is zero
// - clear bit empties its fifo, clears its lost flag, reads zero
// - enabled transmit fifo holding data starts sending once transmit enabled
// - receive error clears receive fifo enable; re-enable refused while error
// - disabling a fifo keeps contents, pointers and count
// - count register reads fifo2 high byte, fifo1 low byte
// - written receive count is threshold; reaching it sets receive full
// - idle over eight baud clocks below threshold sets receive full
// - data read or fifo disable resets idle counter
// - transmit count excludes byte in data register; receive excludes one in progress
// - depth sixteen, maximum count equals depth
// - lost detect enable gates lost flag; save before enabling
module sdfc_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_enable_i,
    input wire logic rx_enable_i,
    input wire logic tx_busy_i,
    input wire logic tx_wr_i,
    input wire sdfc_pkg::sdfc_byte_type tx_wdata_i,
    input wire logic tx_pop_i,
    output logic tx_avail_o,
    output sdfc_pkg::sdfc_byte_type tx_rdata_o,
    input wire logic rx_push_i,
    input wire sdfc_pkg::sdfc_byte_type rx_wdata_i,
    input wire logic rx_rd_i,
    output sdfc_pkg::sdfc_byte_type rx_rdata_o,
    input wire logic rx_error_i,
    input wire logic baud_tick_i,
    input wire logic rx_line_idle_i,
    output logic rx_full_flag_o
);
    import sdfc_pkg::*;

    // ----------------------------------------
    // control bits
    // ----------------------------------------
    logic fe_ff [2];
    logic lost_ff [2];
    logic role_ff;
    logic lost_en_ff;
    logic idle_en_ff;
    logic reload_ff;
    sdfc_ptr_type saved_ff;
    sdfc_byte_type mem_ff [2][`SDFC_DEPTH];
    sdfc_ptr_type wp_ff [2];
    sdfc_ptr_type rp_ff [2];
    sdfc_cnt_type cnt_ff [2];
    sdfc_cnt_type thr_ff [2];
    logic [3:0] idle_ff;
    logic idle_full_ff;
    logic wr_do;
    logic rd_do;
    logic [11:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_ff;
    logic w_ff;
    logic [31:0] rd_word;

    logic txi;
    logic rxi;
    assign txi = role_ff;
    assign rxi = ~role_ff;

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
    assign wr_do = aw_ff & w_ff & ~s_axi_bvalid;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            waddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDFC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                waddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (waddr_ff == `SDFC_OFF_CTRL || waddr_ff == `SDFC_OFF_COUNT)
                    ? `SDFC_RESP_OKAY : `SDFC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic ctl_wr0;
    logic ctl_wr1;
    logic cnt_wr0;
    logic cnt_wr1;
    assign ctl_wr0 = wr_do && waddr_ff == `SDFC_OFF_CTRL && wstrb_ff[0];
    assign ctl_wr1 = wr_do && waddr_ff == `SDFC_OFF_CTRL && wstrb_ff[1];
    assign cnt_wr0 = wr_do && waddr_ff == `SDFC_OFF_COUNT && wstrb_ff[0];
    assign cnt_wr1 = wr_do && waddr_ff == `SDFC_OFF_COUNT && wstrb_ff[1];

    logic clr [2];
    assign clr[0] = ctl_wr0 & wdata_ff[`SDFC_B_FIFO1_CLEAR];
    assign clr[1] = ctl_wr0 & wdata_ff[`SDFC_B_FIFO2_CLEAR];
    // other control writes blocked during reload
    logic ctl_ok;
    assign ctl_ok = ctl_wr0 & ~reload_ff;
    logic save_req;
    // save only with empty transmit count
    assign save_req = ctl_ok & wdata_ff[`SDFC_B_SAVE] & (cnt_ff[txi] == 8'h00);

    // ----------------------------------------
    // enables, role and mode bits
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fe_ff[0] <= 1'b0;
            fe_ff[1] <= 1'b0;
            role_ff <= 1'b0;
            lost_en_ff <= 1'b0;
            idle_en_ff <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ctl_ok) begin
                    // re-enable refused while receive error stands
                    if (!(i == int'(rxi) && rx_error_i && wdata_ff[i])) begin
                        // disable only gates traffic, state kept
                        fe_ff[i] <= wdata_ff[i];
                    end
                end
                if (i == int'(rxi) && rx_error_i) begin
                    fe_ff[i] <= 1'b0;
                end
            end
            // role changes only with both enables off, clears leave it
            if (ctl_wr1 && !reload_ff && !fe_ff[0] && !fe_ff[1]) begin
                role_ff <= wdata_ff[`SDFC_B_SEL];
            end
            if (ctl_wr1 && !reload_ff) begin
                lost_en_ff <= wdata_ff[`SDFC_B_LOST_EN];
                idle_en_ff <= wdata_ff[`SDFC_B_IDLE_EN];
            end
        end
    end

    // ----------------------------------------
    // save, reload and lost flag
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reload_ff <= 1'b0;
            saved_ff <= 4'h0;
        end else begin
            if (save_req) begin
                saved_ff <= rp_ff[txi];
            end
            // reload refused while enabled or transmitting
            if (ctl_ok && wdata_ff[`SDFC_B_RELOAD] && !fe_ff[txi] && !tx_busy_i) begin
                reload_ff <= 1'b1;
            end else begin
                // self-clears after one cycle of copy
                reload_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lost_ff[0] <= 1'b0;
            lost_ff[1] <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // clear or save wipes the flag
                if (clr[i] || (save_req && i == int'(txi))) begin
                    lost_ff[i] <= 1'b0;
                end
                // overwrite of saved slot, set wins over clear
                if (i == int'(txi) && lost_en_ff && tx_wr_i && fe_ff[i] && !reload_ff
                    && wp_ff[i] == saved_ff) begin
                    lost_ff[i] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // circular buffers
    // ----------------------------------------
    logic push [2];
    logic pop [2];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (i == int'(txi)) begin
                push[i] = tx_wr_i & fe_ff[i] & ~reload_ff & (cnt_ff[i] != 8'(`SDFC_DEPTH));
                pop[i] = tx_pop_i & tx_avail_o;
            end else begin
                push[i] = rx_push_i & rx_enable_i & fe_ff[i] & (cnt_ff[i] != 8'(`SDFC_DEPTH));
                pop[i] = rx_rd_i & fe_ff[i] & (cnt_ff[i] != 8'h00);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 2; i++) begin
                wp_ff[i] <= 4'h0;
                rp_ff[i] <= 4'h0;
                cnt_ff[i] <= `SDFC_CNT_RST;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (clr[i]) begin
                    wp_ff[i] <= 4'h0;
                    rp_ff[i] <= 4'h0;
                    cnt_ff[i] <= `SDFC_CNT_RST;
                end else if (reload_ff && i == int'(txi)) begin
                    // rewind read pointer to the saved slot
                    rp_ff[i] <= saved_ff;
                    cnt_ff[i] <= {4'h0, 4'(wp_ff[i] - saved_ff)} + ((wp_ff[i] == saved_ff
                        && cnt_ff[i] != 8'h00) ? 8'(`SDFC_DEPTH) : 8'h00);
                end else begin
                    if (push[i]) begin
                        wp_ff[i] <= wp_ff[i] + 4'h1;
                    end
                    if (pop[i]) begin
                        rp_ff[i] <= rp_ff[i] + 4'h1;
                    end
                    // count of stored entries only, capped at depth
                    cnt_ff[i] <= cnt_ff[i] + 8'(push[i]) - 8'(pop[i]);
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        for (int i = 0; i < 2; i++) begin
            if (push[i]) begin
                mem_ff[i][wp_ff[i]] <= (i == int'(txi)) ? tx_wdata_i : rx_wdata_i;
            end
        end
    end

    // data offered as soon as enabled and transmit is on
    assign tx_avail_o = fe_ff[txi] & tx_enable_i & ~reload_ff & (cnt_ff[txi] != 8'h00);
    assign tx_rdata_o = mem_ff[txi][rp_ff[txi]];
    assign rx_rdata_o = mem_ff[rxi][rp_ff[rxi]];

    // ----------------------------------------
    // threshold and idle detection
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            thr_ff[0] <= `SDFC_THR_RST;
            thr_ff[1] <= `SDFC_THR_RST;
        end else begin
            if (cnt_wr0) begin
                thr_ff[0] <= wdata_ff[7:0];
            end
            if (cnt_wr1) begin
                thr_ff[1] <= wdata_ff[15:8];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            idle_ff <= 4'h0;
            idle_full_ff <= 1'b0;
        end else begin
            // read or disable restarts the idle count
            if (rx_rd_i || !fe_ff[rxi] || !rx_line_idle_i || cnt_ff[rxi] == 8'h00) begin
                idle_ff <= 4'h0;
            end else if (baud_tick_i && idle_ff <= 4'(`SDFC_IDLE_BAUDS)) begin
                idle_ff <= idle_ff + 4'h1;
            end
            // more than eight idle baud clocks below threshold
            if (cnt_ff[rxi] == 8'h00 || clr[rxi]) begin
                idle_full_ff <= 1'b0;
            end else if (idle_en_ff && cnt_ff[rxi] < thr_ff[rxi]
                && idle_ff > 4'(`SDFC_IDLE_BAUDS)) begin
                idle_full_ff <= 1'b1;
            end
        end
    end

    assign rx_full_flag_o = (cnt_ff[rxi] != 8'h00)
        & ((cnt_ff[rxi] >= thr_ff[rxi]) | idle_full_ff);

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        if (s_axi_araddr == `SDFC_OFF_CTRL) begin
            rd_word[`SDFC_B_FE1] = fe_ff[0];
            rd_word[`SDFC_B_FE2] = fe_ff[1];
            rd_word[`SDFC_B_RELOAD] = reload_ff;
            rd_word[`SDFC_B_LOST] = lost_ff[txi];
            rd_word[`SDFC_B_SEL] = role_ff;
            rd_word[`SDFC_B_IDLE_EN] = idle_en_ff;
            rd_word[`SDFC_B_LOST_EN] = lost_en_ff;
        end else if (s_axi_araddr == `SDFC_OFF_COUNT) begin
            // fifo2 high byte, fifo1 low byte
            rd_word[15:0] = {cnt_ff[1], cnt_ff[0]};
        end else if (s_axi_araddr == `SDFC_OFF_STATUS) begin
            rd_word[1:0] = {lost_ff[1], lost_ff[0]};
            rd_word[2] = rx_full_flag_o;
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_do = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SDFC_RESP_OKAY;
        end else if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr == `SDFC_OFF_CTRL || s_axi_araddr == `SDFC_OFF_COUNT
                || s_axi_araddr == `SDFC_OFF_STATUS) ? `SDFC_RESP_OKAY : `SDFC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reload_self_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reload_ff |=> !reload_ff) else $error("reload bit stuck");
    a_reload_rewinds: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        reload_ff && !clr[txi] |=> rp_ff[txi] == $past(saved_ff)) else $error("no rewind");
    a_role_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        fe_ff[0] || fe_ff[1] |=> role_ff == $past(role_ff)) else $error("role changed");
    a_clear_empties: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clr[0] |=> cnt_ff[0] == 8'h00 && !lost_ff[0]) else $error("clear failed");
    a_rx_err_drop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rx_error_i |=> !fe_ff[$past(rxi)]) else $error("enable kept on error");
    a_save_gated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !save_req && !reload_ff |=> saved_ff == $past(saved_ff)) else $error("bad save");
    a_full_thresh: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cnt_ff[rxi] != 8'h00 && cnt_ff[rxi] >= thr_ff[rxi] |-> rx_full_flag_o)
        else $error("full not set");
    a_lost_set: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        lost_en_ff && tx_wr_i && fe_ff[txi] && !reload_ff && wp_ff[txi] == saved_ff
        |=> lost_ff[$past(txi)]) else $error("lost not set");
    a_disable_keeps: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !fe_ff[rxi] && !clr[rxi] && !ctl_wr1 |=> $stable(cnt_ff[rxi]))
        else $error("count moved while off");
endmodule : sdfc_top
`default_nettype wire

// file: shared/sdfc_params.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * dual fifo control block; assumes a 32-bit axi4-lite register bus.
 */
`ifndef SDFC_PARAMS_SVH
`define SDFC_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SDFC_OFF_CTRL 12'h000
`define SDFC_OFF_COUNT 12'h004
`define SDFC_OFF_STATUS 12'h008
// ----------------------------------------
// control word field positions
// ----------------------------------------
`define SDFC_B_FE1 0
`define SDFC_B_FE2 1
`define SDFC_B_FIFO1_CLEAR 2
`define SDFC_B_FIFO2_CLEAR 3
`define SDFC_B_SAVE 4
`define SDFC_B_RELOAD 5
`define SDFC_B_LOST 6
`define SDFC_B_SEL 8
`define SDFC_B_IDLE_EN 11
`define SDFC_B_LOST_EN 12
// ----------------------------------------
// sizes, resets, timing
// ----------------------------------------
`define SDFC_DEPTH 16
`define SDFC_PTR_W 4
`define SDFC_CNT_W 8
`define SDFC_CNT_RST 8'h00
`define SDFC_THR_RST 8'h08
`define SDFC_IDLE_BAUDS 8
`define SDFC_RESP_OKAY 2'h0
`define SDFC_RESP_SLVERR 2'h2
`endif

// file: shared/sdfc_pkg.sv
/*
 * types of the dual fifo control block; assumes sdfc_params.svh is
 * on the include path.
 */
`default_nettype none
package sdfc_pkg;
    typedef logic [7:0] sdfc_byte_type;
    typedef logic [3:0] sdfc_ptr_type;
    typedef logic [7:0] sdfc_cnt_type;
endpackage : sdfc_pkg
`default_nettype wire

// file: verif/sdfc_engine_model.sv
/*
 * shift engine model: takes bytes from the transmit fifo, reports
 * each one, keeps busy while shifting and makes free-running baud ticks.
 * assumes the fifo block runs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sdfc_engine_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tx_avail_i,
    input wire sdfc_pkg::sdfc_byte_type tx_rdata_i,
    input wire logic hold_i,
    output logic tx_pop_o,
    output logic tx_busy_o,
    output logic baud_tick_o,
    output logic got_o,
    output sdfc_pkg::sdfc_byte_type got_data_o
);
    import sdfc_pkg::*;
    logic [2:0] busy_ff;
    logic [1:0] div_ff;
    // ----------------------------------------
    // transmit side
    // ----------------------------------------
    // hold stretches busy, so the bench can stall the engine
    assign tx_busy_o = busy_ff != 3'h0 || hold_i;
    assign tx_pop_o = tx_avail_i && !tx_busy_o;
    always_ff @(posedge clock_i) begin
        got_o <= tx_pop_o;
        if (tx_pop_o) begin
            got_data_o <= tx_rdata_i;
            busy_ff <= 3'h3;
        end else if (busy_ff != 3'h0) begin
            busy_ff <= busy_ff - 3'h1;
        end
        if (!rst_n_i) begin
            busy_ff <= 3'h0;
        end
    end
    always_ff @(posedge clock_i) begin
        div_ff <= rst_n_i ? div_ff + 2'h1 : 2'h0;
        baud_tick_o <= rst_n_i && div_ff == 2'h3;
    end
endmodule : sdfc_engine_model
`default_nettype wire

// file: verif/sdfc_top_tb.sv
/*
 * bench of the dual fifo control block: axi4-lite master, engine
 * model, receive stimulus and a queue scoreboard.
 * assumes sdfc_pkg compiled first and sdfc_params.svh on the path.
 */
`timescale 1ns/1ps
`include "sdfc_params.svh"
`default_nettype none
`define SDFC_CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("BAD %0t got %0h want %0h", $time, g, e); \
    end \
end
module sdfc_top_tb;
    import sdfc_pkg::*;
    localparam logic [11:0] ctl = `SDFC_OFF_CTRL;
    localparam logic [11:0] cnt = `SDFC_OFF_COUNT;
    localparam logic [11:0] sts = `SDFC_OFF_STATUS;
    localparam logic [1:0] slverr = `SDFC_RESP_SLVERR;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, hold = 1'h0;
    logic tx_enable_i = 1'h0, rx_enable_i = 1'h0, tx_wr_i = 1'h0, rx_push_i = 1'h0;
    logic rx_rd_i = 1'h0, rx_error_i = 1'h0, rx_line_idle_i = 1'h0;
    sdfc_byte_type tx_wdata_i = '0, rx_wdata_i = '0, got_b, tx_rdata_o, rx_rdata_o, t;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    logic tx_busy_i, tx_pop_i, tx_avail_o, baud_tick_i, rx_full_flag_o, got;
    logic [65:0] e;
    int err_total = 0, tests_run = 0;
    sdfc_byte_type txq[$], rxq[$], rep[$];
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    always #20 clock_i = ~clock_i;
    sdfc_top dut (.clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_enable_i,
        .rx_enable_i, .tx_busy_i, .tx_wr_i, .tx_wdata_i, .tx_pop_i, .tx_avail_o,
        .tx_rdata_o, .rx_push_i, .rx_wdata_i, .rx_rd_i, .rx_rdata_o, .rx_error_i,
        .baud_tick_i, .rx_line_idle_i, .rx_full_flag_o);
    sdfc_engine_model eng (.clock_i, .rst_n_i, .tx_avail_i(tx_avail_o),
        .tx_rdata_i(tx_rdata_o), .hold_i(hold), .tx_pop_o(tx_pop_i),
        .tx_busy_o(tx_busy_i), .baud_tick_o(baud_tick_i), .got_o(got), .got_data_o(got_b));
    // ----------------------------------------
    // scoreboard: oldest note against each result
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.size() != 0 ? rq.pop_front() : '1;
            `SDFC_CHK(s_axi_rresp, e[65:64])
            `SDFC_CHK(s_axi_rdata & e[63:32], e[31:0])
        end
        if (s_axi_bvalid && s_axi_bready) begin
            br = bq.size() != 0 ? bq.pop_front() : 2'h3;
            `SDFC_CHK(s_axi_bresp, br)
        end
        if (got) begin
            t = txq.size() != 0 ? txq.pop_front() : ~got_b;
            `SDFC_CHK(got_b, t)
        end
        if (rx_rd_i) begin
            t = rxq.size() != 0 ? rxq.pop_front() : ~rx_rdata_o;
            `SDFC_CHK(rx_rdata_o, t)
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r = `SDFC_RESP_OKAY);
        logic pa, pw, ta, tw;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        pa = 1'h1;
        pw = 1'h1;
        while (pa || pw) begin
            @(negedge clock_i);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge clock_i);
            pa = pa && !ta;
            pw = pw && !tw;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(negedge clock_i); while (!s_axi_bvalid);
        @(posedge clock_i);
        s_axi_bready <= 1'h0;
        @(posedge clock_i);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic [1:0] r = `SDFC_RESP_OKAY);
        rq.push_back({r, m, x});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge clock_i); while (!s_axi_arready);
        @(posedge clock_i);
        s_axi_arvalid <= 1'h0;
        do @(negedge clock_i); while (!s_axi_rvalid);
        @(posedge clock_i);
        s_axi_rready <= 1'h0;
        @(posedge clock_i);
    endtask : rd
    task automatic txw(input int n);
        sdfc_byte_type b;
        repeat (n) begin
            b = sdfc_byte_type'($urandom);
            txq.push_back(b);
            rep.push_back(b);
            tx_wdata_i <= b;
            tx_wr_i <= 1'h1;
            @(posedge clock_i);
        end
        tx_wr_i <= 1'h0;
        @(posedge clock_i);
    endtask : txw
    task automatic rxp(input int n);
        sdfc_byte_type b;
        repeat (n) begin
            b = sdfc_byte_type'($urandom);
            rxq.push_back(b);
            rx_wdata_i <= b;
            rx_push_i <= 1'h1;
            @(posedge clock_i);
        end
        rx_push_i <= 1'h0;
        @(posedge clock_i);
    endtask : rxp
    task automatic rxr(input int n);
        repeat (n) begin
            rx_rd_i <= 1'h1;
            @(posedge clock_i);
        end
        rx_rd_i <= 1'h0;
        @(posedge clock_i);
    endtask : rxr
    task automatic drain;
        while (txq.size() != 0) @(negedge clock_i);
        @(posedge clock_i);
    endtask : drain
    task automatic ticks(input int n);
        repeat (n) begin
            do @(negedge clock_i); while (!baud_tick_i);
        end
        @(posedge clock_i);
    endtask : ticks
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hF65E));
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'h1;
        @(posedge clock_i);
        rd(ctl, 32'h197F, 32'h0);
        rd(cnt, 32'hFFFF, 32'h0);
        rd(sts, 32'h7, 32'h0);
        rd(12'h00C, 32'h0, 32'h0, slverr);
        wr(12'h00C, 32'h1, 4'hF, slverr);
        wr(ctl, 32'h803, 4'h3);
        txw(16);
        rd(cnt, 32'hFF, 32'h10);
        wr(ctl, 32'h802, 4'h3);
        rd(cnt, 32'hFF, 32'h10);
        wr(ctl, 32'h803, 4'h3);
        tx_enable_i <= 1'h1;
        drain();
        txw(3);
        hold <= 1'h1;
        rd(cnt, 32'hFF, 32'h2);
        hold <= 1'h0;
        drain();
        wr(cnt, 32'h300, 4'h2);
        rx_enable_i <= 1'h1;
        rxp(2);
        rd(sts, 32'h4, 32'h0);
        rxp(1);
        rd(sts, 32'h4, 32'h4);
        rd(cnt, 32'hFF00, 32'h300);
        rxr(3);
        rx_line_idle_i <= 1'h1;
        rxp(1);
        ticks(6);
        rxp(1);
        rxr(1);
        ticks(6);
        rd(sts, 32'h4, 32'h0);
        ticks(4);
        rd(sts, 32'h4, 32'h4);
        rxr(1);
        rd(sts, 32'h4, 32'h0);
        rx_error_i <= 1'h1;
        @(posedge clock_i);
        rd(ctl, 32'h3, 32'h1);
        wr(ctl, 32'h803, 4'h3);
        rd(ctl, 32'h3, 32'h1);
        rx_error_i <= 1'h0;
        wr(ctl, 32'h803, 4'h3);
        rd(ctl, 32'h3, 32'h3);
        tx_enable_i <= 1'h0;
        wr(ctl, 32'h100, 4'h3);
        rd(ctl, 32'h103, 32'h0);
        wr(ctl, 32'h103, 4'h3);
        rd(ctl, 32'h103, 32'h103);
        rxp(2);
        rd(cnt, 32'hFFFF, 32'h2);
        rx_enable_i <= 1'h0;
        wr(ctl, 32'h107, 4'h3);
        rd(ctl, 32'h11F, 32'h103);
        rd(cnt, 32'hFF, 32'h0);
        rxq.delete();
        rx_enable_i <= 1'h1;
        rxp(1);
        rxr(1);
        wr(ctl, 32'h113, 4'h3);
        rep.delete();
        txw(3);
        rd(sts, 32'h2, 32'h0);
        tx_enable_i <= 1'h1;
        drain();
        wr(ctl, 32'h123, 4'h3);
        rd(cnt, 32'hFF00, 32'h0);
        tx_enable_i <= 1'h0;
        wr(ctl, 32'h101, 4'h3);
        wr(ctl, 32'h121, 4'h3);
        rd(ctl, 32'h20, 32'h0);
        rd(cnt, 32'hFF00, 32'h300);
        txq = rep;
        wr(ctl, 32'h103, 4'h3);
        tx_enable_i <= 1'h1;
        drain();
        wr(ctl, 32'h1103, 4'h3);
        txw(13);
        rd(sts, 32'h2, 32'h0);
        txw(1);
        rd(sts, 32'h2, 32'h2);
        rd(ctl, 32'h40, 32'h40);
        drain();
        wr(ctl, 32'h1113, 4'h3);
        rd(sts, 32'h2, 32'h0);
        report_and_stop();
    end
endmodule : sdfc_top_tb
`default_nettype wire
